// *** common/lecs_cnt_if.sv ***
`timescale 1ns/10ps
interface lecs_cnt_if #(
    parameter int LANES = 4,
    parameter int CNT_W = 12
);
    logic [LANES-1:0] enable;
    logic [2:0] select;
    logic clearPulse;
    logic [CNT_W-1:0] count [LANES];

    modport ctrl (output enable, output select, output clearPulse, input count);
    modport bank (input enable, input select, input clearPulse, output count);
endinterface

// *** common/lecs_pkg.sv ***
// What this block does
// - lane 0 count bits 11:8 at 0x19
// - lane 1 count low 0x1a, high 0x1b
// - lane 2 count low 0x1c, high 0x1d
// - lane 3 count low 0x1e, high 0x1f
// - power-down flag at 0x20 bit 7
// - standby flag at 0x20 bit 6
// - three-bit code selects counted error source
// - counter-clear rising edge zeroes all counters
// - per-lane enable bits gate counting
package lecs_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int LANES = 4;
    localparam int CNT_W = 12;
    localparam int NUM_SRC = 5;
    localparam int HIGH_LSB = 8;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CLEAR_CTL = 8'h15;
    localparam logic [7:0] OFS_CHECK_CTL = 8'h16;
    localparam logic [7:0] OFS_L0_HIGH = 8'h19;
    localparam logic [7:0] OFS_L1_LOW = 8'h1a;
    localparam logic [7:0] OFS_L1_HIGH = 8'h1b;
    localparam logic [7:0] OFS_L2_LOW = 8'h1c;
    localparam logic [7:0] OFS_L2_HIGH = 8'h1d;
    localparam logic [7:0] OFS_L3_LOW = 8'h1e;
    localparam logic [7:0] OFS_L3_HIGH = 8'h1f;
    localparam logic [7:0] OFS_POWER = 8'h20;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int POS_PWR_DOWN = 7;
    localparam int POS_STANDBY = 6;
    localparam int POS_CLEAR = 4;
    localparam int POS_ENABLE = 4;
    localparam int POS_SELECT = 0;
    localparam logic [3:0] RST_ENABLE = 4'h0;
    localparam logic [2:0] RST_SELECT = 3'h0;

    // ----------------------------------------------------------------
    // error sources and serial port states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_DATA = 3'h0,
        SRC_BUFFER = 3'h1,
        SRC_OVERFLOW = 3'h2,
        SRC_UNDERFLOW = 3'h3,
        SRC_DESKEW = 3'h4
    } lecs_src_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_WRITE = 3'h2,
        ST_ACK_OUT = 3'h3,
        ST_READ = 3'h4,
        ST_ACK_IN = 3'h5
    } lecs_state_e;

endpackage

// *** tb/lecs_checker.sv ***
`timescale 1ns/10ps
module lecs_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [lecs_pkg::LANES*lecs_pkg::NUM_SRC-1:0] laneEvents,
    input wire logic poweredDownIn,
    input wire logic standbyIn
);
    // ----------------------------------------------------------------
    // serial pin timing
    // ----------------------------------------------------------------
    logic [7:0] sclHigh;
    logic [7:0] next_sclHigh;
    always_comb begin
        next_sclHigh = (sclHigh == 8'hff) ? sclHigh : sclHigh + 8'h01;
        if (!scl) begin
            next_sclHigh = 8'h00;
        end
    end
    always_ff @(posedge clk) begin
        sclHigh <= srst ? 8'h00 : next_sclHigh;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    out_low_a: assert property (sdaOut == 1'b0)
        else $error("data pin drive value not low");
    oe_reset_a: assert property ($fell(srst) |-> !sdaOe)
        else $error("data pin pulled low after reset");
    oe_phase_a: assert property ($changed(sdaOe) |-> !scl && !$past(scl))
        else $error("data pin drive changed near a high clock");
    // two sync flops: no reaction to a clock fall within two cycles
    oe_lag_a: assert property ($fell(scl) |-> $stable(sdaOe) ##1 $stable(sdaOe))
        else $error("data pin drive reacted too early");
    oe_hold_a: assert property ($rose(scl) |-> $stable(sdaOe) [*4])
        else $error("data pin drive changed after clock rise");
    oe_rise_a: assert property ($rose(sdaOe) |-> !scl [*3])
        else $error("data pin pulled low outside the low phase");
    start_quiet_a: assert property (scl && $fell(sdaIn) |-> !sdaOe [*4])
        else $error("data pin pulled low right after start");
    idle_free_a: assert property (sclHigh > 8'h0c |-> !sdaOe)
        else $error("data pin held low on an idle bus");
endmodule

// *** tb/lecs_i2c_host.sv ***
`timescale 1ns/10ps
module lecs_i2c_host #(
    parameter int HALF = 8
) (
    input wire logic clk,
    input wire logic sdaBus,
    output logic scl,
    output logic sdaLow
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic pause(input int n);
        repeat (n) @(negedge clk);
    endtask
    // works from idle and as repeated start with the clock low
    task automatic start_cond();
        sdaLow = 1'b0;
        pause(HALF);
        scl = 1'b1;
        pause(HALF);
        sdaLow = 1'b1;
        pause(HALF);
        scl = 1'b0;
        pause(2);
    endtask
    task automatic stop_cond();
        sdaLow = 1'b1;
        pause(HALF);
        scl = 1'b1;
        pause(HALF);
        sdaLow = 1'b0;
        pause(HALF);
    endtask
    // data changes two cycles after the clock fall so the slave's
    // synchronisers never see data move while the clock is high
    task automatic byte_io(input logic [7:0] tx, input logic ackIn,
                           output logic [7:0] rx, output logic ackOut);
        logic [8:0] sh;
        logic [8:0] got;
        sh = {tx, ackIn};
        for (int i = 8; i >= 0; i--) begin
            sdaLow = !sh[i];
            pause(HALF);
            scl = 1'b1;
            pause(HALF);
            got[i] = sdaBus;
            scl = 1'b0;
            pause(2);
        end
        rx = got[8:1];
        ackOut = got[0];
    endtask
endmodule

// *** tb/lecs_status_regs_tb_top.sv ***
`timescale 1ns/10ps
module lecs_status_regs_tb_top;
    // ----------------------------------------------------------------
    // bench wiring and bus tasks
    // ----------------------------------------------------------------
    localparam logic [6:0] DEV = 7'h2c;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [lecs_pkg::LANES*lecs_pkg::NUM_SRC-1:0] laneEvents = '0;
    logic poweredDownIn = 1'b0;
    logic standbyIn = 1'b0;
    logic scl;
    logic sdaLow;
    logic sdaOut;
    logic sdaOe;
    logic [7:0] rd [9];
    int failures = 0;
    int n_compared = 0;
    // open drain with pull-up: high unless someone pulls low
    wire sdaBus = !(sdaOe || sdaLow);
    always #20 clk = !clk;
    lecs_status_regs #(.DEV_ADDR(DEV)) DUT (.clk(clk), .srst(srst), .scl(scl),
        .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe), .laneEvents(laneEvents),
        .poweredDownIn(poweredDownIn), .standbyIn(standbyIn));
    lecs_i2c_host host (.clk(clk), .sdaBus(sdaBus), .scl(scl), .sdaLow(sdaLow));
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_ack(input logic got);
        n_compared++;
        if (got !== 1'b0) begin
            failures++;
            $display("MISMATCH t=%0t ack got=%h exp=%h", $time, got, 1'b0);
        end
    endtask
    task automatic addr_phase(input logic [7:0] addr);
        logic [7:0] rx;
        logic ack;
        host.start_cond();
        host.byte_io({DEV, 1'b0}, 1'b1, rx, ack);
        check_ack(ack);
        host.byte_io(addr, 1'b1, rx, ack);
        check_ack(ack);
    endtask
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] rx;
        logic ack;
        addr_phase(addr);
        host.byte_io(data, 1'b1, rx, ack);
        check_ack(ack);
        host.stop_cond();
    endtask
    task automatic read_regs(input logic [7:0] addr, input int n);
        logic [7:0] rx;
        logic ack;
        addr_phase(addr);
        host.start_cond();
        host.byte_io({DEV, 1'b1}, 1'b1, rx, ack);
        check_ack(ack);
        for (int i = 0; i < n; i++) begin
            host.byte_io(8'hff, (i == n - 1), rd[i], ack);
        end
        host.stop_cond();
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic check_all_zero();
        read_regs(8'h18, 9);
        for (int i = 0; i < 9; i++) check_byte(rd[i], 8'h00);
    endtask
    task automatic test_counts();
        logic [11:0] cnt [4];
        cnt = '{12'h1a5, 12'h2c3, 12'h0f7, 12'h301};
        write_reg(8'h16, 8'hf0);
        // buffer-error line held high throughout: must not count
        for (int c = 0; c < 800; c++) begin
            @(negedge clk);
            for (int l = 0; l < 4; l++) begin
                laneEvents[l*5] = (c < cnt[l]);
                laneEvents[l*5+1] = 1'b1;
            end
        end
        @(negedge clk);
        laneEvents = '0;
        read_regs(8'h19, 7);
        check_byte(rd[0], {4'h0, cnt[0][11:8]});
        for (int l = 1; l < 4; l++) begin
            check_byte(rd[2*l-1], cnt[l][7:0]);
            check_byte(rd[2*l], {4'h0, cnt[l][11:8]});
        end
        $display("test_counts done");
    endtask
    task automatic test_sources();
        for (int code = 0; code < 8; code++) begin
            write_reg(8'h15, 8'h10);
            write_reg(8'h16, {4'h2, 1'b0, code[2:0]});
            // three cycles on every source, two more on the selected one only,
            // so a wrong source pick reads 3 instead of 5
            laneEvents = '1;
            repeat (3) @(negedge clk);
            laneEvents = (code < 5) ? 20'h1 << (5 + code) : 20'h0;
            repeat (2) @(negedge clk);
            laneEvents = '0;
            read_regs(8'h1a, 3);
            check_byte(rd[0], (code < 5) ? 8'h05 : 8'h00);
            check_byte(rd[1], 8'h00);
            check_byte(rd[2], 8'h00);
        end
        $display("test_sources done");
    endtask
    task automatic test_flags();
        logic [7:0] exp [3];
        exp = '{8'h80, 8'h40, 8'hc0};
        for (int i = 0; i < 3; i++) begin
            poweredDownIn = exp[i][7];
            standbyIn = exp[i][6];
            read_regs(8'h20, 1);
            check_byte(rd[0], exp[i]);
        end
        poweredDownIn = 1'b0;
        standbyIn = 1'b0;
        $display("test_flags done");
    endtask
    task automatic test_readonly();
        write_reg(8'h19, 8'hff);
        write_reg(8'h1a, 8'hff);
        write_reg(8'h20, 8'hff);
        check_all_zero();
        $display("test_readonly done");
    endtask
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        check_all_zero();
        $display("test_reset done");
        test_counts();
        test_sources();
        test_flags();
        test_readonly();
        end_sim();
    end
    // about 28k cycles expected; generous margin
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        $display("MISMATCH t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
        end_sim();
    end
endmodule
bind lecs_status_regs lecs_checker chk (.clk(clk), .srst(srst), .scl(scl), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .laneEvents(laneEvents),
    .poweredDownIn(poweredDownIn), .standbyIn(standbyIn));

// *** verilog/lecs_lane_counters.sv ***
`timescale 1ns/10ps
module lecs_lane_counters #(
    parameter int LANES = 4,
    parameter int CNT_W = 12,
    parameter int NUM_SRC = 5
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [LANES*NUM_SRC-1:0] laneEvents,
    lecs_cnt_if.bank bus
);

    // ----------------------------------------------------------------
    // one saturating counter per lane
    // ----------------------------------------------------------------
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] next_count;
        logic hit;

        always_comb begin
            hit = 1'b0;
            // reserved codes count nothing
            if (bus.select <= lecs_pkg::SRC_DESKEW) begin
                hit = laneEvents[l*NUM_SRC + int'(bus.select)];
            end
            next_count = count;
            if (bus.clearPulse) begin
                next_count = '0;
            end else if (bus.enable[l] && hit && count != {CNT_W{1'b1}}) begin
                next_count = count + 1'b1;
            end
        end

        always_ff @(posedge clk) begin
            if (srst) begin
                count <= '0;
            end else begin
                count <= next_count;
            end
        end

        assign bus.count[l] = count;
    end

endmodule

// *** verilog/lecs_status_regs.sv ***
`timescale 1ns/10ps
module lecs_status_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2c
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [lecs_pkg::LANES*lecs_pkg::NUM_SRC-1:0] laneEvents,
    input wire logic poweredDownIn,
    input wire logic standbyIn
);

    localparam int CW = lecs_pkg::CNT_W;
    localparam int HL = lecs_pkg::HIGH_LSB;

    lecs_cnt_if #(.LANES(lecs_pkg::LANES), .CNT_W(CW)) cntBus ();

    lecs_lane_counters #(
        .LANES(lecs_pkg::LANES),
        .CNT_W(CW),
        .NUM_SRC(lecs_pkg::NUM_SRC)
    ) u_counters (
        .clk(clk),
        .srst(srst),
        .laneEvents(laneEvents),
        .bus(cntBus.bank)
    );

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic sclMeta, sclSync, sclPrev;
    logic sdaMeta, sdaSync, sdaPrev;

    always_ff @(posedge clk) begin
        if (srst) begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sclPrev <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclMeta <= scl;
            sclSync <= sclMeta;
            sclPrev <= sclSync;
            sdaMeta <= sdaIn;
            sdaSync <= sdaMeta;
            sdaPrev <= sdaSync;
        end
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    lecs_pkg::lecs_state_e state, next_state;
    logic [7:0] shift, next_shift;
    logic [3:0] bitCnt, next_bitCnt;
    logic [7:0] ptr, next_ptr;
    logic isRead, next_isRead;
    logic firstByte, next_firstByte;
    logic oe, next_oe;
    logic clearCtl, next_clearCtl;
    logic clearPulse, next_clearPulse;
    logic [3:0] enable, next_enable;
    logic [2:0] select, next_select;
    logic powerDown, standby;
    logic [CW-1:0] laneCount [lecs_pkg::LANES];

    assign laneCount = cntBus.count;
    assign cntBus.enable = enable;
    assign cntBus.select = select;
    assign cntBus.clearPulse = clearPulse;

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    function automatic logic [7:0] readReg(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == lecs_pkg::OFS_L0_HIGH) begin
            r[CW-HL-1:0] = laneCount[0][CW-1:HL];
        end else if (a == lecs_pkg::OFS_L1_LOW) begin
            r = laneCount[1][HL-1:0];
        end else if (a == lecs_pkg::OFS_L1_HIGH) begin
            r[CW-HL-1:0] = laneCount[1][CW-1:HL];
        end else if (a == lecs_pkg::OFS_L2_LOW) begin
            r = laneCount[2][HL-1:0];
        end else if (a == lecs_pkg::OFS_L2_HIGH) begin
            r[CW-HL-1:0] = laneCount[2][CW-1:HL];
        end else if (a == lecs_pkg::OFS_L3_LOW) begin
            r = laneCount[3][HL-1:0];
        end else if (a == lecs_pkg::OFS_L3_HIGH) begin
            r[CW-HL-1:0] = laneCount[3][CW-1:HL];
        end else if (a == lecs_pkg::OFS_POWER) begin
            r[lecs_pkg::POS_PWR_DOWN] = powerDown;
            r[lecs_pkg::POS_STANDBY] = standby;
        end else if (a == lecs_pkg::OFS_CLEAR_CTL) begin
            r[lecs_pkg::POS_CLEAR] = clearCtl;
        end else if (a == lecs_pkg::OFS_CHECK_CTL) begin
            r[lecs_pkg::POS_ENABLE +: 4] = enable;
            r[lecs_pkg::POS_SELECT +: 3] = select;
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    logic sclRise, sclFall, startCond, stopCond;
    logic [7:0] rdByte;

    always_comb begin
        sclRise = sclSync & ~sclPrev;
        sclFall = ~sclSync & sclPrev;
        startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
        stopCond = sclSync & sclPrev & ~sdaPrev & sdaSync;
        rdByte = readReg(ptr);
        next_state = state;
        next_shift = shift;
        next_bitCnt = bitCnt;
        next_ptr = ptr;
        next_isRead = isRead;
        next_firstByte = firstByte;
        next_oe = oe;
        next_enable = enable;
        next_select = select;
        next_clearPulse = 1'b0;
        // the clear bit drops by itself once its pulse has gone out
        next_clearCtl = clearPulse ? 1'b0 : clearCtl;
        if (startCond) begin
            next_state = lecs_pkg::ST_ADDR;
            next_bitCnt = 4'h0;
            next_oe = 1'b0;
        end else if (stopCond) begin
            next_state = lecs_pkg::ST_IDLE;
            next_oe = 1'b0;
        end else if (sclRise) begin
            case (state)
                lecs_pkg::ST_ADDR, lecs_pkg::ST_WRITE: begin
                    next_shift = {shift[6:0], sdaSync};
                    next_bitCnt = bitCnt + 4'h1;
                end
                lecs_pkg::ST_ACK_IN: begin
                    // master not-acknowledge ends the read
                    if (sdaSync) begin
                        next_state = lecs_pkg::ST_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (sclFall) begin
            case (state)
                lecs_pkg::ST_ADDR: begin
                    if (bitCnt == 4'h8) begin
                        if (shift[7:1] == DEV_ADDR) begin
                            next_state = lecs_pkg::ST_ACK_OUT;
                            next_isRead = shift[0];
                            next_firstByte = 1'b1;
                            next_oe = 1'b1;
                        end else begin
                            next_state = lecs_pkg::ST_IDLE;
                        end
                    end
                end
                lecs_pkg::ST_WRITE: begin
                    if (bitCnt == 4'h8) begin
                        next_state = lecs_pkg::ST_ACK_OUT;
                        next_oe = 1'b1;
                        next_firstByte = 1'b0;
                        if (firstByte) begin
                            next_ptr = shift;
                        end else begin
                            next_ptr = ptr + 8'h01;
                            // status registers take no writes
                            if (ptr == lecs_pkg::OFS_CLEAR_CTL) begin
                                next_clearCtl = shift[lecs_pkg::POS_CLEAR];
                                // only a 0 to 1 change fires the clear
                                next_clearPulse = shift[lecs_pkg::POS_CLEAR] & ~clearCtl;
                            end else if (ptr == lecs_pkg::OFS_CHECK_CTL) begin
                                next_enable = shift[lecs_pkg::POS_ENABLE +: 4];
                                next_select = shift[lecs_pkg::POS_SELECT +: 3];
                            end
                        end
                    end
                end
                lecs_pkg::ST_ACK_OUT, lecs_pkg::ST_ACK_IN: begin
                    if (state == lecs_pkg::ST_ACK_OUT && !isRead) begin
                        next_state = lecs_pkg::ST_WRITE;
                        next_bitCnt = 4'h0;
                        next_oe = 1'b0;
                    end else begin
                        next_state = lecs_pkg::ST_READ;
                        next_oe = ~rdByte[7];
                        next_shift = {rdByte[6:0], 1'b0};
                        next_bitCnt = 4'h1;
                        next_ptr = ptr + 8'h01;
                    end
                end
                lecs_pkg::ST_READ: begin
                    if (bitCnt == 4'h8) begin
                        next_state = lecs_pkg::ST_ACK_IN;
                        next_oe = 1'b0;
                    end else begin
                        next_oe = ~shift[7];
                        next_shift = {shift[6:0], 1'b0};
                        next_bitCnt = bitCnt + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= lecs_pkg::ST_IDLE;
            shift <= 8'h00;
            bitCnt <= 4'h0;
            ptr <= 8'h00;
            isRead <= 1'b0;
            firstByte <= 1'b0;
            oe <= 1'b0;
            clearCtl <= 1'b0;
            clearPulse <= 1'b0;
            enable <= lecs_pkg::RST_ENABLE;
            select <= lecs_pkg::RST_SELECT;
            powerDown <= 1'b0;
            standby <= 1'b0;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
        end else begin
            state <= next_state;
            shift <= next_shift;
            bitCnt <= next_bitCnt;
            ptr <= next_ptr;
            isRead <= next_isRead;
            firstByte <= next_firstByte;
            oe <= next_oe;
            clearCtl <= next_clearCtl;
            clearPulse <= next_clearPulse;
            enable <= next_enable;
            select <= next_select;
            powerDown <= poweredDownIn;
            standby <= standbyIn;
            sdaOut <= 1'b0;
            sdaOe <= next_oe;
        end
    end

endmodule
